/* freeze_mode_entry_gate.sv */
`include "freeze_gate_defines.svh"

module freeze_mode_entry_gate
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic freeze_request_pin_n,
  input  wire logic entry_gate_signal,
  input  wire logic mode_pin_logic,
  output logic      freeze_active,
  output logic      gate_still_high
);

  logic                           pin_meta_r;
  logic                           pin_sync_r;
  logic                           pin_req;
  logic                           pin_and_logic;
  logic                           gate_ok;
  logic                           freeze_nxt;
  logic                           rearm_nxt;
  freeze_gate_pkg::freeze_state_t state_r;
  freeze_gate_pkg::freeze_state_t state_nxt;

  // Two flops; the first feeds only the second
  // A pin pulse shorter than one clock may be missed
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_meta_r <= `PIN_RELEASED;
      pin_sync_r <= `PIN_RELEASED;
    end
    else
    begin
      pin_meta_r <= freeze_request_pin_n;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Pin polarity is decoded once, after the synchroniser
  always_comb
  begin
    if (pin_sync_r == `PIN_ASSERTED)
    begin
      pin_req = 1'b1;
    end
    else
    begin
      pin_req = 1'b0;
    end
  end

  always_comb
  begin
    if (mode_pin_logic == `MODE_PIN_LOGIC)
    begin
      pin_and_logic = 1'b1;
    end
    else
    begin
      pin_and_logic = 1'b0;
    end
  end

  // In pin-and-logic mode the gate qualifies entry and also decides when ST_REARM returns to ST_RUN
  always_comb
  begin
    if (!pin_and_logic)
    begin
      gate_ok = 1'b1;
    end
    else if (entry_gate_signal == `GATE_ASSERTED)
    begin
      gate_ok = 1'b1;
    end
    else
    begin
      gate_ok = 1'b0;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      freeze_gate_pkg::ST_RUN:
      begin
        if (pin_req && gate_ok)
        begin
          state_nxt = freeze_gate_pkg::ST_FROZEN;
        end
        else
        begin
          state_nxt = freeze_gate_pkg::ST_RUN;
        end
      end

      freeze_gate_pkg::ST_FROZEN:
      begin
        if (!pin_req)
        begin
          state_nxt = freeze_gate_pkg::ST_REARM;
        end
        else
        begin
          state_nxt = freeze_gate_pkg::ST_FROZEN;
        end
      end

      freeze_gate_pkg::ST_REARM:
      begin
        // In pin-and-logic mode wait for the gate to fall so a stale high gate cannot re-freeze; pin-only mode returns at once
        if (!gate_ok || !pin_and_logic)
        begin
          state_nxt = freeze_gate_pkg::ST_RUN;
        end
        else
        begin
          state_nxt = freeze_gate_pkg::ST_REARM;
        end
      end

      default:
      begin
        state_nxt = freeze_gate_pkg::ST_RUN;
      end
    endcase
  end

  // Outputs mirror the next state so they line up with the state register
  always_comb
  begin
    freeze_nxt = 1'b0;
    unique case (state_nxt)
      freeze_gate_pkg::ST_RUN:
      begin
        freeze_nxt = 1'b0;
      end
      freeze_gate_pkg::ST_FROZEN:
      begin
        freeze_nxt = 1'b1;
      end
      freeze_gate_pkg::ST_REARM:
      begin
        freeze_nxt = 1'b0;
      end
      default:
      begin
        freeze_nxt = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    rearm_nxt = 1'b0;
    unique case (state_nxt)
      freeze_gate_pkg::ST_RUN:
      begin
        rearm_nxt = 1'b0;
      end
      freeze_gate_pkg::ST_FROZEN:
      begin
        rearm_nxt = 1'b0;
      end
      freeze_gate_pkg::ST_REARM:
      begin
        rearm_nxt = 1'b1;
      end
      default:
      begin
        rearm_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_r <= freeze_gate_pkg::ST_RUN;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Registered so the pin-side logic never sees a decode glitch
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      freeze_active <= `OUT_IDLE;
    end
    else
    begin
      freeze_active <= freeze_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      gate_still_high <= `OUT_IDLE;
    end
    else
    begin
      gate_still_high <= rearm_nxt;
    end
  end

endmodule : freeze_mode_entry_gate

/* freeze_gate_defines.svh */
`ifndef FREEZE_GATE_DEFINES_SVH
`define FREEZE_GATE_DEFINES_SVH
`define PIN_ASSERTED   1'b0
`define PIN_RELEASED   1'b1
`define GATE_ASSERTED  1'b1
`define SYNC_RESET     2'b11
`define OUT_IDLE       1'b0
`define MODE_PIN_ONLY  1'b0
`define MODE_PIN_LOGIC 1'b1
`endif

/* freeze_gate_pkg.sv */
package freeze_gate_pkg;
  typedef enum logic [1:0]
  {
    ST_RUN    = 2'b00,
    ST_FROZEN = 2'b01,
    ST_REARM  = 2'b10
  } freeze_state_t;
endpackage : freeze_gate_pkg

/* fz_chk.sv */
module fz_chk
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic freeze_request_pin_n,
  input wire logic entry_gate_signal,
  input wire logic mode_pin_logic,
  input wire logic freeze_active,
  input wire logic gate_still_high
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_entry_both: assert property ($rose(freeze_active) |-> !$past(freeze_request_pin_n, 3)
    && ($past(entry_gate_signal) || !$past(mode_pin_logic))) else $error("bad entry");
  chk_exit_release: assert property ($fell(freeze_active) |-> $past(freeze_request_pin_n, 3))
    else $error("bad exit");
  chk_gate_holds_off: assert property (!freeze_active && mode_pin_logic && !entry_gate_signal |=> !freeze_active)
    else $error("entry without gate");
  chk_rearm_drop: assert property (gate_still_high && (!entry_gate_signal || !mode_pin_logic) |=> !gate_still_high)
    else $error("rearm stuck");
  chk_rearm_apart: assert property (!(freeze_active && gate_still_high)) else $error("overlap");
endmodule : fz_chk
bind freeze_mode_entry_gate fz_chk i_chk(.*);

/* fz_user.sv */
module fz_user
(
  input  wire logic mclk,
  input  wire logic ready,
  input  wire logic gate_still_high,
  output logic      gate
);
  timeunit 1ns;
  timeprecision 100ps;
  // Gate only after work is done, dropped on rearm
  always_ff @(posedge mclk) gate <= ready && !gate_still_high;
endmodule : fz_user

/* freeze_mode_entry_gate_bench.sv */
module freeze_mode_entry_gate_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst_n = 0, pin_n = 1, mode = 0, ready = 0, probe = 0, gate, fa, gsh;
  int n_mismatch = 0, samples_checked = 0;
  logic q[$], qg[$];
  always #2.5 mclk = ~mclk;
  freeze_mode_entry_gate i_dut(.mclk, .rst_n, .freeze_request_pin_n(pin_n), .entry_gate_signal(gate),
    .mode_pin_logic(mode), .freeze_active(fa), .gate_still_high(gsh));
  fz_user i_usr(.mclk, .ready, .gate_still_high(gsh), .gate);
  task chk(logic seen, logic exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask : chk
  // Outputs are looked at mid-cycle, where they are settled
  always @(negedge mclk)
  begin
    if (probe)
    begin
      chk(fa, q.pop_front());
      chk(gsh, qg.pop_front());
    end
  end
  task step(int n);
    repeat (n) @(posedge mclk);
  endtask : step
  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task note(logic e, logic g);
    q.push_back(e);
    qg.push_back(g);
    probe <= 1;
    step(1);
    probe <= 0;
  endtask : note
  initial
  begin
    void'($urandom(68558));
    step(16);
    rst_n <= 1;
    for (int t = 0; t < 4; t++)
    begin
      mode <= t[1];
      ready <= t[0];
      step(2 + $urandom % 4);
      pin_n <= 0;
      step(4);
      note(t[0] | !t[1], 1'b0);
      pin_n <= 1;
      step(4);
      note(1'b0, t[1] & t[0]);
      ready <= 0;
      step(4);
      $display("test %0d done", t);
    end
    conclude();
  end
endmodule : freeze_mode_entry_gate_bench
